//--- hw/mhp_device.sv
// Device end: slave side of the multi-mode parallel host port
`timescale 1ns/1ps

// Summary of operation
// - Separate-strobe: write captured at strobe rising edge
// - Enable-clock: write pin high reads, low writes
// - Data-strobe: write pin high reads, low writes
// - Respond only while chip select asserted low
// - Separate-strobe: wait low stretches, high completes
// - Data-strobe: acknowledge held off until transfer ready
// - Host may handshake on wait in indirect mode
// - Enable-clock: host ignores wait/acknowledge output
// - Reset returns registers and outputs inactive
// - Static straps select bus style and addressing
// - Read pin role differs per bus style
// - Indirect: low address bit tags data kind
// - Data bus tristated, driven only during reads
module mhp_device (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Straps
	input wire logic [1:0] bus_style_select,
	input wire logic addressing_mode_select,
	// Host bus pins
	mhp_bus_if.device bus,
	// User side: captured writes and data to return on reads
	input wire logic [7:0] read_value,
	output logic [7:0] wr_data,
	output logic wr_is_cmd,
	output logic wr_valid,
	output logic rd_done,
	output logic indirect_mode
);

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every host pin the device uses (addr_hi and d_host_oe are not sampled)

	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [7:0] d1_r;
	logic [7:0] d2_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 4'hf;
			s2_r <= 4'hf;
			d1_r <= mhp_pkg::DATA_RST;
			d2_r <= mhp_pkg::DATA_RST;
		end else begin
			s1_r <= {bus.cs_n, bus.rd_pin, bus.wr_pin, bus.cmd_data_select};
			s2_r <= s1_r;
			d1_r <= bus.d_host_o;
			d2_r <= d1_r;
		end
	end

	wire cs_act = ~s2_r[3];
	wire rd_s = s2_r[2];
	wire wr_s = s2_r[1];
	wire a0_s = s2_r[0];

	////////////////////////////////////////////////////////////////////////
	// Straps pass two flops, then are caught once after reset release

	logic [2:0] strap1_r;
	logic [2:0] strap2_r;
	logic [1:0] settle_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap1_r <= 3'h0;
			strap2_r <= 3'h0;
			settle_r <= 2'h0;
		end else begin
			strap1_r <= {addressing_mode_select, bus_style_select};
			strap2_r <= strap1_r;
			settle_r <= {settle_r[0], 1'b1};
		end
	end

	// Caught only once the second flop holds a pin value, not its reset value
	logic strap_done_r;
	mhp_pkg::mhp_style_t style_r;
	logic indirect_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_r <= 1'b0;
			style_r <= mhp_pkg::MHP_STYLE_STROBE;
			indirect_r <= 1'b0;
		end else if (!strap_done_r && settle_r[1]) begin
			strap_done_r <= 1'b1;
			style_r <= mhp_pkg::mhp_style_t'(strap2_r[1:0]);
			indirect_r <= strap2_r[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decode of an active access per style

	wire is_strobe = style_r == mhp_pkg::MHP_STYLE_STROBE;
	wire is_dstrobe = style_r == mhp_pkg::MHP_STYLE_DSTROBE;
	wire is_enclk = style_r == mhp_pkg::MHP_STYLE_ENCLK;
	// read pin low is read enable / data strobe, high is enable clock
	wire strobe_rd = is_strobe & ~rd_s;
	wire strobe_wr = is_strobe & ~wr_s;
	wire ds_act = is_dstrobe & ~rd_s;
	wire en_act = is_enclk & rd_s;
	wire access = strap_done_r & cs_act & (strobe_rd | strobe_wr | ds_act | en_act);
	wire dir_read = is_strobe ? strobe_rd : wr_s;
	wire handshake = is_strobe | is_dstrobe;

	////////////////////////////////////////////////////////////////////////
	// Access state machine

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_HOLD = 2'h1,
		ST_DONE = 2'h2
	} mhp_dstate_t;

	mhp_dstate_t st_r;
	mhp_dstate_t st_nxt;
	logic [3:0] cnt_r;
	logic rd_cyc_r;

	wire cnt_end = cnt_r == mhp_pkg::ACK_DELAY;
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: if (access) st_nxt = ST_HOLD;
			ST_HOLD: if (!access) st_nxt = ST_IDLE; else if (cnt_end) st_nxt = ST_DONE;
			ST_DONE: if (!access) st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
	end

	// Write taken once, when the strobe ends after the device completed
	wire wr_end = (st_r == ST_DONE) & ~access & ~rd_cyc_r;
	wire rd_end = (st_r == ST_DONE) & ~access & rd_cyc_r;
	wire wr_take = access & ~dir_read;
	wire wait_hold = access & (st_nxt == ST_HOLD);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			rd_cyc_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= (st_r == ST_HOLD) ? cnt_r + 4'h1 : 4'h0;
			if (st_r == ST_IDLE && access) rd_cyc_r <= dir_read;
		end
	end

	// Data sampled while strobe still active, committed at its end
	logic [7:0] wr_data_r;
	logic wr_is_cmd_r;
	logic wr_valid_r;
	logic rd_done_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_data_r <= mhp_pkg::DATA_RST;
			wr_is_cmd_r <= 1'b0;
			wr_valid_r <= 1'b0;
			rd_done_r <= 1'b0;
		end else begin
			if (wr_take) begin
				wr_data_r <= d2_r;
				wr_is_cmd_r <= indirect_r & a0_s;
			end
			wr_valid_r <= wr_end;
			rd_done_r <= rd_end;
		end
	end

	// Pin drivers: all start released so nothing fights the host after reset
	logic [7:0] dout_r;
	logic dout_oe_r;
	logic wait_r;
	logic wait_oe_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dout_r <= mhp_pkg::DATA_RST;
			dout_oe_r <= 1'b0;
			wait_r <= 1'b1;
			wait_oe_r <= 1'b0;
		end else begin
			dout_r <= read_value;
			dout_oe_r <= access & dir_read;
			// Wait low while held, high when done, released with the strobe
			wait_r <= ~wait_hold;
			wait_oe_r <= access & handshake;
		end
	end

	assign wr_data = wr_data_r;
	assign wr_is_cmd = wr_is_cmd_r;
	assign wr_valid = wr_valid_r;
	assign rd_done = rd_done_r;
	assign indirect_mode = indirect_r;
	assign bus.d_dev_o = dout_r;
	assign bus.d_dev_oe = dout_oe_r;
	assign bus.wait_o = wait_r;
	assign bus.wait_oe = wait_oe_r;

endmodule : mhp_device

//--- hw/mhp_pkg.sv
// Package: shared constants and types for the multi-mode host bus port
package mhp_pkg;

	typedef enum logic [1:0] {
		MHP_STYLE_STROBE = 2'h0,
		MHP_STYLE_DSTROBE = 2'h1,
		MHP_STYLE_ENCLK = 2'h2,
		MHP_STYLE_RSVD = 2'h3
	} mhp_style_t;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	// The device holds off the host for this many cycles plus one before completing a transfer
	localparam logic [3:0] ACK_DELAY = 4'h3;
	// Host side: strobe low time and idle time, in clk_sys cycles
	localparam logic [3:0] HOST_STROBE_CYC = 4'h8;
	localparam logic [3:0] HOST_IDLE_CYC = 4'h4;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] READ_VALUE_RST = 8'h00;

endpackage : mhp_pkg

//--- hw/mhp_bus_if.sv
// Interface: host bus pins between host and device ends
`timescale 1ns/1ps
interface mhp_bus_if;
	logic cs_n;
	logic rd_pin;
	logic wr_pin;
	logic cmd_data_select;
	logic [15:1] addr_hi;
	logic [7:0] d_host_o;
	logic d_host_oe;
	logic [7:0] d_dev_o;
	logic d_dev_oe;
	logic wait_o;
	logic wait_oe;

	modport device (
		input cs_n, rd_pin, wr_pin, cmd_data_select, addr_hi, d_host_o, d_host_oe,
		output d_dev_o, d_dev_oe, wait_o, wait_oe
	);
	modport host (
		output cs_n, rd_pin, wr_pin, cmd_data_select, addr_hi, d_host_o, d_host_oe,
		input d_dev_o, d_dev_oe, wait_o, wait_oe
	);
endinterface : mhp_bus_if

//--- hw/mhp_host.sv
// Host end: drives one access at a time on the multi-mode host port
`timescale 1ns/1ps
module mhp_host (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Bus style, same value as the device straps
	input wire logic [1:0] bus_style_select,
	// User request
	input wire logic req,
	input wire logic req_write,
	input wire logic req_cmd,
	input wire logic [7:0] req_data,
	output logic busy,
	output logic done,
	output logic [7:0] rd_data,
	// Host bus pins
	mhp_bus_if.host bus
);

	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_STROBE = 2'h1,
		HS_GAP = 2'h2
	} mhp_hstate_t;

	mhp_hstate_t st_r;
	logic [3:0] cnt_r;
	logic [1:0] w_sync_r;
	logic wr_r;
	logic cs_n_r;
	logic act_r;
	logic [7:0] dat_r;
	logic a0_r;
	logic done_r;
	logic [7:0] rd_r;

	wire [1:0] style = bus_style_select;
	wire is_strobe = style == 2'h0;
	wire is_enclk = style == 2'h2;
	// Enable-clock style has no handshake; others wait for the pin to read high
	wire wait_ok = is_enclk | w_sync_r[1];
	wire min_ok = cnt_r >= mhp_pkg::HOST_STROBE_CYC;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			w_sync_r <= 2'h3;
		end else begin
			// A released pin reads high through its pull-up; the minimum strobe
			// length outlasts the device's delay in pulling it low
			w_sync_r <= {w_sync_r[0], ~bus.wait_oe | bus.wait_o};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= HS_IDLE;
			cnt_r <= 4'h0;
			wr_r <= 1'b0;
			cs_n_r <= 1'b1;
			act_r <= 1'b0;
			dat_r <= mhp_pkg::DATA_RST;
			a0_r <= 1'b0;
			done_r <= 1'b0;
			rd_r <= mhp_pkg::DATA_RST;
		end else begin
			done_r <= 1'b0;
			unique case (st_r)
				HS_IDLE: if (req) begin
					st_r <= HS_STROBE;
					cnt_r <= 4'h0;
					cs_n_r <= 1'b0;
					act_r <= 1'b1;
					wr_r <= req_write;
					dat_r <= req_data;
					a0_r <= req_cmd;
				end
				HS_STROBE: begin
					if (!min_ok) cnt_r <= cnt_r + 4'h1;
					if (min_ok && wait_ok) begin
						st_r <= HS_GAP;
						cnt_r <= 4'h0;
						act_r <= 1'b0;
						done_r <= 1'b1;
						if (!wr_r) rd_r <= bus.d_dev_o;
					end
				end
				HS_GAP: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == mhp_pkg::HOST_IDLE_CYC) begin
						st_r <= HS_IDLE;
						cs_n_r <= 1'b1;
					end
				end
				default: st_r <= HS_IDLE;
			endcase
		end
	end

	// Pin roles per style
	wire rd_strobe = is_strobe ? ~(act_r & ~wr_r) : (is_enclk ? act_r : ~act_r);
	wire wr_strobe = is_strobe ? ~(act_r & wr_r) : ~wr_r;
	assign bus.cs_n = cs_n_r;
	assign bus.rd_pin = rd_strobe;
	assign bus.wr_pin = wr_strobe;
	assign bus.cmd_data_select = a0_r;
	assign bus.addr_hi = 15'h0000;
	assign bus.d_host_o = dat_r;
	assign bus.d_host_oe = ~cs_n_r & wr_r;
	assign busy = st_r != HS_IDLE;
	assign done = done_r;
	assign rd_data = rd_r;

endmodule : mhp_host

//--- verif/mhp_chk.sv
// Checker: timing relations on the host port wires
`timescale 1ns/1ps
module mhp_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Bus wires
	input wire logic cs_n,
	input wire logic wr_pin,
	input wire logic d_host_oe,
	input wire logic d_dev_oe,
	input wire logic wait_o,
	input wire logic wait_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	a_idle_wait_off: assert property (cs_n [*4] |-> !wait_oe)
		else $error("wait driven while deselected");
	a_idle_bus_off: assert property (cs_n [*4] |-> !d_dev_oe)
		else $error("data driven while deselected");
	a_no_bus_fight: assert property (!(d_dev_oe && d_host_oe))
		else $error("both ends drive data");
	a_wait_starts_low: assert property ($rose(wait_oe) |-> !wait_o)
		else $error("wait released high at start");
	a_sync_before_act: assert property ($rose(wait_oe) |-> !cs_n && $past(!cs_n, 2))
		else $error("wait before strobe synchronised");
	a_wait_ends_soon: assert property (wait_oe && !wait_o |-> ##[1:6] wait_o)
		else $error("wait held too long");
	a_release_after_done: assert property ($fell(wait_oe) |-> $past(wait_o))
		else $error("wait released before completion");
	a_read_drive_dir: assert property ($rose(d_dev_oe) |-> wr_pin && !cs_n)
		else $error("data driven outside a read");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !wait_oe && !d_dev_oe)
		else $error("outputs active in reset");
	c_wait: cover property ($rose(wait_oe));
	c_read: cover property ($rose(d_dev_oe));
	c_release: cover property ($fell(wait_oe));
endmodule : mhp_chk

//--- verif/tb.sv
// Testbench: host and device ends joined across the port
`timescale 1ns/1ps
module tb;
	logic clk_sys;
	logic rst_n;
	logic [1:0] style;
	logic ind;
	logic req;
	logic req_write;
	logic req_cmd;
	logic [7:0] req_data;
	logic [7:0] read_value;
	logic busy;
	logic done;
	logic [7:0] rd_data;
	logic [7:0] wr_data;
	logic wr_is_cmd;
	logic wr_valid;
	logic rd_done;
	logic indirect_mode;
	logic [7:0] last_wr;
	logic last_cmd;
	int wr_cnt;
	int rd_cnt;
	int wait_cnt;
	int failures;
	int n_compared;
	mhp_bus_if bus ();
	mhp_device mhp_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus_style_select(style),
		.addressing_mode_select(ind), .bus(bus), .read_value(read_value), .wr_data(wr_data),
		.wr_is_cmd(wr_is_cmd), .wr_valid(wr_valid), .rd_done(rd_done),
		.indirect_mode(indirect_mode));
	mhp_host mhp_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus_style_select(style),
		.req(req), .req_write(req_write), .req_cmd(req_cmd), .req_data(req_data),
		.busy(busy), .done(done), .rd_data(rd_data), .bus(bus));
	mhp_chk mhp_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(bus.cs_n),
		.wr_pin(bus.wr_pin), .d_host_oe(bus.d_host_oe), .d_dev_oe(bus.d_dev_oe),
		.wait_o(bus.wait_o), .wait_oe(bus.wait_oe));
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (wr_valid === 1'b1) begin
			wr_cnt++;
			last_wr = wr_data;
			last_cmd = wr_is_cmd;
		end
		if (rd_done === 1'b1) rd_cnt++;
		if (bus.wait_oe === 1'b1) wait_cnt++;
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_of_test();
		if (failures == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	// Straps are only read after reset release, so a new mode means a new reset;
	// they settle through two flops and are caught on the third edge
	task automatic restart(input logic [1:0] s, input logic i);
		rst_n <= 1'b0;
		style <= s;
		ind <= i;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask : restart
	task automatic access(input logic w, input logic c, input logic [7:0] d);
		int k;
		k = 0;
		req_write <= w;
		req_cmd <= c;
		req_data <= d;
		req <= 1'b1;
		@(posedge clk_sys);
		req <= 1'b0;
		while (done !== 1'b1 && k < 200) begin
			@(posedge clk_sys);
			k++;
		end
		if (k == 200) chk("done", 8'h01, 8'h00);
		repeat (10) @(posedge clk_sys);
		chk("busy", 8'h00, {7'h00, busy});
		chk("cs after access", 8'h01, {7'h00, bus.cs_n});
	endtask : access
	////////////////////////////////////////////////////////////////
	task automatic t_write_read(input logic [1:0] s);
		int wc;
		int rc;
		int hc;
		restart(s, 1'b0);
		hc = wait_cnt;
		for (int v = 0; v < 2; v++) begin
			wc = wr_cnt;
			rc = rd_cnt;
			access(1'b1, 1'b1, v ? 8'h00 : 8'hff);
			chk("write count", 8'(wc + 1), 8'(wr_cnt));
			chk("write data", v ? 8'h00 : 8'hff, last_wr);
			chk("cmd flag", 8'h00, {7'h00, last_cmd});
			read_value <= v ? 8'h3c : 8'hc3;
			access(1'b0, 1'b0, 8'h00);
			chk("read data", v ? 8'h3c : 8'hc3, rd_data);
			chk("read count", 8'(rc + 1), 8'(rd_cnt));
			chk("no write on read", 8'(wc + 1), 8'(wr_cnt));
		end
		chk("handshake", (s == 2'h2) ? 8'h00 : 8'h01, {7'h00, wait_cnt != hc});
	endtask : t_write_read
	task automatic t_indirect_cmd();
		restart(2'h0, 1'b1);
		chk("indirect", 8'h01, {7'h00, indirect_mode});
		access(1'b1, 1'b1, 8'h81);
		chk("cmd flag", 8'h01, {7'h00, last_cmd});
		access(1'b1, 1'b0, 8'h18);
		chk("data flag", 8'h00, {7'h00, last_cmd});
		chk("data", 8'h18, last_wr);
	endtask : t_indirect_cmd
	task automatic t_reserved_style();
		int wc;
		restart(2'h3, 1'b0);
		wc = wr_cnt;
		req_write <= 1'b1;
		req_data <= 8'h55;
		req <= 1'b1;
		@(posedge clk_sys);
		req <= 1'b0;
		repeat (40) @(posedge clk_sys);
		chk("reserved writes", 8'(wc), 8'(wr_cnt));
		chk("reserved wait oe", 8'h00, {7'h00, bus.wait_oe});
	endtask : t_reserved_style
	task automatic t_reset_midrun();
		int wc;
		restart(2'h0, 1'b0);
		wc = wr_cnt;
		req_write <= 1'b1;
		req_data <= 8'h66;
		req <= 1'b1;
		@(posedge clk_sys);
		req <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("wait oe", 8'h00, {7'h00, bus.wait_oe});
		chk("data oe", 8'h00, {7'h00, bus.d_dev_oe});
		chk("cs", 8'h01, {7'h00, bus.cs_n});
		chk("aborted write", 8'(wc), 8'(wr_cnt));
	endtask : t_reset_midrun
	////////////////////////////////////////////////////////////////
	initial begin
		// High at time zero so the first reset is a real falling edge
		rst_n = 1'b1;
		style = 2'h0;
		ind = 1'b0;
		req = 1'b0;
		req_write = 1'b0;
		req_cmd = 1'b0;
		req_data = 8'h00;
		read_value = 8'h00;
		t_write_read(2'h0);
		t_write_read(2'h1);
		t_write_read(2'h2);
		t_indirect_cmd();
		t_reserved_style();
		t_reset_midrun();
		t_write_read(2'h0);
		end_of_test();
	end
	// Whole run is well under 3000 cycles; this allows several times that
	initial begin
		#500000;
		failures++;
		end_of_test();
	end
endmodule : tb
